// [rtl/mlpsp_pkg.sv]
// Constants for the two-port multilevel shutdown rank block.
// Assumes a single 200 MHz core clock and byte-wide management register access.
package mlpsp_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] PORT_PAIR_SHUTDOWN_RANK_CMD = 8'h28;
    localparam logic [7:0] PORT_PAIR_SHUTDOWN_RANK_RST = 8'h00;
    localparam int RANK_A_LSB = 0;
    localparam int RANK_B_LSB = 4;
    localparam int RANK_W = 3;

    // ************************************************************
    // Serial code timing
    // ************************************************************
    localparam int CLK_FREQ_MHZ = 200;
    localparam int SERIAL_BIT_NS = 1000;
    localparam int SERIAL_BIT_CYCLES = (SERIAL_BIT_NS * CLK_FREQ_MHZ) / 1000;
    localparam int SERIAL_HALF_CYCLES = SERIAL_BIT_CYCLES / 2;
    localparam int SERIAL_CODE_BITS = 3;
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {
        MLPSP_IDLE = 2'b00,
        MLPSP_START = 2'b01,
        MLPSP_DATA = 2'b10,
        MLPSP_APPLY = 2'b11
    } mlpsp_state_e;

endpackage

// [rtl/mlpsp_core.sv]
// Shutdown rank register for ports 3 and 4 and the serial fast shutdown receiver.
// Assumes the management interface decodes a command byte and a write strobe,
// and that the serial line idles high and is synchronous to sys_clk.
//
// Operation
// [RULE1] Three-bit rank per port, bits 6:4 and 2:0
// [RULE2] Ranks apply only when multilevel select is set
// [RULE3] Serial shutdown code selects ports to power off
// [RULE4] Rank 000 highest priority, 111 lowest
// [RULE5] Power off ports with rank at least code
// [RULE6] Turn-off like reset, cool-down count continues
// [RULE7] Rank byte is read/write at command 28h
// [RULE8] Ranks clear to zero on reset
`timescale 1ns/1ps
`default_nettype none

module mlpsp_core
    import mlpsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_cmd,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_hit,
    input wire logic multilevel_rank_select,
    input wire logic fast_shutdown_serial_input,
    output logic [1:0] port_off_req,
    output logic keep_cooldown,
    output logic [2:0] last_code,
    output logic code_valid
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Larger rank value means lower priority, so a port falls when its
    // rank is not below the received code.
    function automatic logic rank_hit(input logic [2:0] rank, input logic [2:0] code);
        begin
            rank_hit = (rank >= code); // [RULE4] [RULE5]
        end
    endfunction

    // ************************************************************
    // Rank register
    // ************************************************************
    logic [2:0] port_shutdown_rank_a_q;
    logic [2:0] port_shutdown_rank_a_d;
    logic [2:0] port_shutdown_rank_b_q;
    logic [2:0] port_shutdown_rank_b_d;
    logic [7:0] reg_rd_data_q;
    logic [7:0] reg_rd_data_d;
    logic cmd_hit;

    assign cmd_hit = (reg_cmd == PORT_PAIR_SHUTDOWN_RANK_CMD); // [RULE7]

    always_comb
    begin
        port_shutdown_rank_a_d = port_shutdown_rank_a_q;
        port_shutdown_rank_b_d = port_shutdown_rank_b_q;
        if (cmd_hit && reg_wr_en)
        begin
            // Bits 7 and 3 are unused and are not stored
            port_shutdown_rank_a_d = reg_wr_data[RANK_A_LSB +: RANK_W]; // [RULE1] [RULE7]
            port_shutdown_rank_b_d = reg_wr_data[RANK_B_LSB +: RANK_W]; // [RULE1] [RULE7]
        end
        reg_rd_data_d = 8'h00;
        if (cmd_hit)
        begin
            reg_rd_data_d[RANK_A_LSB +: RANK_W] = port_shutdown_rank_a_d; // [RULE1]
            reg_rd_data_d[RANK_B_LSB +: RANK_W] = port_shutdown_rank_b_d; // [RULE1]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_shutdown_rank_a_q <= PORT_PAIR_SHUTDOWN_RANK_RST[RANK_A_LSB +: RANK_W]; // [RULE8]
            port_shutdown_rank_b_q <= PORT_PAIR_SHUTDOWN_RANK_RST[RANK_B_LSB +: RANK_W]; // [RULE8]
            reg_rd_data_q <= 8'h00;
        end
        else
        begin
            port_shutdown_rank_a_q <= port_shutdown_rank_a_d;
            port_shutdown_rank_b_q <= port_shutdown_rank_b_d;
            reg_rd_data_q <= reg_rd_data_d;
        end
    end

    assign reg_rd_data = reg_rd_data_q;
    assign reg_rd_hit = cmd_hit;

    // ************************************************************
    // Serial code receiver
    // ************************************************************
    // Frame: low start bit, then three data bits MSB first, each one bit
    // time long, sampled in the middle of the bit.
    mlpsp_state_e state_q;
    mlpsp_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [1:0] bits_q;
    logic [1:0] bits_d;
    logic [2:0] shift_q;
    logic [2:0] shift_d;
    logic line_prev_q;
    logic [1:0] port_off_q;
    logic [1:0] port_off_d;
    logic [2:0] last_code_q;
    logic [2:0] last_code_d;
    logic code_valid_q;
    logic code_valid_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        bits_d = bits_q;
        shift_d = shift_q;
        port_off_d = 2'b00;
        last_code_d = last_code_q;
        code_valid_d = 1'b0;
        case (state_q)
            MLPSP_IDLE:
            begin
                if (line_prev_q && !fast_shutdown_serial_input)
                begin
                    state_d = MLPSP_START;
                    cnt_d = CNT_W'(SERIAL_HALF_CYCLES - 1);
                end
            end
            MLPSP_START:
            begin
                if (cnt_q != '0)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else if (fast_shutdown_serial_input)
                begin
                    // Glitch shorter than half a bit: not a frame
                    state_d = MLPSP_IDLE;
                end
                else
                begin
                    state_d = MLPSP_DATA;
                    cnt_d = CNT_W'(SERIAL_BIT_CYCLES - 1);
                    bits_d = 2'b00;
                end
            end
            MLPSP_DATA:
            begin
                if (cnt_q != '0)
                begin
                    cnt_d = cnt_q - 1'b1;
                end
                else
                begin
                    shift_d = {shift_q[1:0], fast_shutdown_serial_input}; // [RULE3]
                    cnt_d = CNT_W'(SERIAL_BIT_CYCLES - 1);
                    bits_d = bits_q + 1'b1;
                    if (bits_q == 2'(SERIAL_CODE_BITS - 1))
                    begin
                        state_d = MLPSP_APPLY;
                    end
                end
            end
            MLPSP_APPLY:
            begin
                last_code_d = shift_q;
                code_valid_d = 1'b1;
                if (multilevel_rank_select) // [RULE2]
                begin
                    port_off_d[0] = rank_hit(port_shutdown_rank_a_q, shift_q); // [RULE3] [RULE5]
                    port_off_d[1] = rank_hit(port_shutdown_rank_b_q, shift_q); // [RULE3] [RULE5]
                end
                state_d = MLPSP_IDLE;
            end
            default:
            begin
                state_d = MLPSP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= MLPSP_IDLE;
            cnt_q <= '0;
            bits_q <= 2'b00;
            shift_q <= 3'h0;
            line_prev_q <= 1'b1;
            port_off_q <= 2'b00;
            last_code_q <= 3'h0;
            code_valid_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bits_q <= bits_d;
            shift_q <= shift_d;
            line_prev_q <= fast_shutdown_serial_input;
            port_off_q <= port_off_d;
            last_code_q <= last_code_d;
            code_valid_q <= code_valid_d;
        end
    end

    // ************************************************************
    // Turn-off request
    // ************************************************************
    // The port sequencer runs its usual reset turn-off on port_off_req;
    // keep_cooldown tells it not to cancel a running fault cool-down.
    assign port_off_req = port_off_q; // [RULE6]
    assign keep_cooldown = |port_off_q; // [RULE6]
    assign last_code = last_code_q;
    assign code_valid = code_valid_q;

endmodule

`default_nettype wire

// [tb/mlpsp_core_properties.sv]
// Checker for the port pair shutdown rank block.
// Assumes it is bound to mlpsp_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mlpsp_core_chk
    import mlpsp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_cmd,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    input wire logic multilevel_rank_select,
    input wire logic [1:0] port_off_req,
    input wire logic keep_cooldown,
    input wire logic [2:0] last_code,
    input wire logic code_valid
);
    logic [7:0] rank_q;
    logic hit;
    assign hit = reg_cmd == PORT_PAIR_SHUTDOWN_RANK_CMD;
    // Mirror of the stored ranks with the unused bits dropped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rank_q <= 8'h00;
        else if (reg_wr_en && hit)
            rank_q <= reg_wr_data & 8'h77;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_unused_bits: assert property (
        !reg_rd_data[7] && !reg_rd_data[3]) else $error("unused bit set");
    a_select_gate: assert property (
        port_off_req != 2'h0 |-> $past(multilevel_rank_select)) else $error("select low");
    a_code_cause: assert property (
        port_off_req != 2'h0 |-> code_valid) else $error("off without code");
    a_top_code: assert property (
        code_valid && last_code == 3'h0 && $past(multilevel_rank_select) |->
        port_off_req == 2'h3) else $error("code zero spared a port");
    a_rank_compare: assert property (
        code_valid && $past(multilevel_rank_select) |-> port_off_req ==
        {$past(rank_q[6:4]) >= last_code, $past(rank_q[2:0]) >= last_code})
        else $error("wrong ports off");
    a_cooldown_kept: assert property (
        keep_cooldown == (port_off_req != 2'h0)) else $error("cool-down flag");
    a_rank_read: assert property (
        hit |=> reg_rd_data == rank_q) else $error("rank read");
    a_reset_zero: assert property (
        !$past(rst_n) && hit && !reg_wr_en |=> reg_rd_data == 8'h00) else $error("not clear");
endmodule
`default_nettype wire
bind mlpsp_core mlpsp_core_chk chk_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_cmd(reg_cmd),
    .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data),
    .multilevel_rank_select(multilevel_rank_select),
    .port_off_req(port_off_req),
    .keep_cooldown(keep_cooldown),
    .last_code(last_code),
    .code_valid(code_valid)
);

// [tb/mlpsp_host_model.sv]
// Host model driving the serial fast shutdown line.
// Assumes send is called just after a rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module mlpsp_host_model
    import mlpsp_pkg::*;
(
    input wire logic sys_clk,
    output var logic fast_shutdown_serial_input
);
    initial fast_shutdown_serial_input = 1'b1;
    // Low start bit, code MSB first, then a high stop bit so frames never merge
    task automatic send(input logic [2:0] code);
        fast_shutdown_serial_input <= 1'b0;
        repeat (SERIAL_BIT_CYCLES) @(posedge sys_clk);
        for (int i = 2; i >= 0; i--)
        begin
            fast_shutdown_serial_input <= code[i];
            repeat (SERIAL_BIT_CYCLES) @(posedge sys_clk);
        end
        fast_shutdown_serial_input <= 1'b1;
        repeat (SERIAL_BIT_CYCLES) @(posedge sys_clk);
    endtask
    // Short low pulse then idle high; long enough idle for any false frame to show
    task automatic pulse_low(input int low_cycles);
        fast_shutdown_serial_input <= 1'b0;
        repeat (low_cycles) @(posedge sys_clk);
        fast_shutdown_serial_input <= 1'b1;
        repeat (SERIAL_BIT_CYCLES * 5) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// [tb/test_multilevel_port_shutdown_priority.sv]
// Bench for the port pair shutdown rank block.
// Assumes the host model drives the serial line and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module test_multilevel_port_shutdown_priority
    import mlpsp_pkg::*;
;
    logic sys_clk, rst_n, reg_wr_en, reg_rd_hit, multilevel_rank_select;
    logic fast_shutdown_serial_input, keep_cooldown, code_valid;
    logic [7:0] reg_cmd, reg_wr_data, reg_rd_data;
    logic [2:0] last_code;
    logic [2:0] seen;
    logic [1:0] port_off_req;
    int failures, samples_checked, cycles, pulses;
    mlpsp_core dut_u (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .reg_cmd(reg_cmd),
        .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data),
        .reg_rd_hit(reg_rd_hit),
        .multilevel_rank_select(multilevel_rank_select),
        .fast_shutdown_serial_input(fast_shutdown_serial_input),
        .port_off_req(port_off_req),
        .keep_cooldown(keep_cooldown),
        .last_code(last_code),
        .code_valid(code_valid)
    );
    mlpsp_host_model host_u (
        .sys_clk(sys_clk),
        .fast_shutdown_serial_input(fast_shutdown_serial_input)
    );
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            print_verdict();
        end
        // Only this process writes seen and pulses; tasks read them
        if (code_valid === 1'b1)
        begin
            seen = {keep_cooldown, port_off_req};
            pulses++;
        end
    end
    task automatic print_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
        @(posedge sys_clk);
        reg_cmd <= cmd;
        reg_wr_en <= 1'b1;
        reg_wr_data <= data;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_cmd <= cmd;
        @(posedge sys_clk);
        #1 check(reg_rd_data, exp);
        check({7'h00, reg_rd_hit}, {7'h00, cmd == PORT_PAIR_SHUTDOWN_RANK_CMD});
    endtask
    task automatic frame(input logic [2:0] code, input logic [1:0] offs);
        int pulses_at_start;
        @(posedge sys_clk);
        pulses_at_start = pulses;
        host_u.send(code);
        check(8'(pulses - pulses_at_start), 8'h01);
        check({5'h00, last_code}, {5'h00, code});
        check({5'h00, seen}, {5'h00, |offs, offs});
    endtask
    task automatic glitch(input int low_cycles);
        int pulses_at_start;
        @(posedge sys_clk);
        pulses_at_start = pulses;
        host_u.pulse_low(low_cycles);
        check(8'(pulses - pulses_at_start), 8'h00);
    endtask
    initial
    begin
        rst_n = 1'b0;
        reg_cmd = PORT_PAIR_SHUTDOWN_RANK_CMD;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        multilevel_rank_select = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(PORT_PAIR_SHUTDOWN_RANK_CMD, 8'h00);
        wr(PORT_PAIR_SHUTDOWN_RANK_CMD, 8'hFF);
        rd(PORT_PAIR_SHUTDOWN_RANK_CMD, 8'h77);
        wr(8'h29, 8'h00);
        rd(8'h29, 8'h00);
        rd(PORT_PAIR_SHUTDOWN_RANK_CMD, 8'h77);
        wr(PORT_PAIR_SHUTDOWN_RANK_CMD, 8'h25);
        // Port 4 ranked 2, port 3 ranked 5: codes 0-2 turn off both, 3-5 only port 3, 6-7 neither
        for (int c = 0; c < 8; c++)
            frame(c[2:0], {c <= 2, c <= 5});
        // A low pulse shorter than half a bit must not be taken as a code
        glitch(SERIAL_HALF_CYCLES / 2);
        multilevel_rank_select <= 1'b0;
        frame(3'h0, 2'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
